// ===== hdl/pch_pkg.sv
// Constants for the configuration header identification and latency slice.
package pch_pkg;

  // ----------------------------------------------------------------
  // Configuration byte addresses (08h and 0Ch dword aligned, 0Eh inside the 0Ch dword)
  // ----------------------------------------------------------------
  localparam logic [7:0] CLASS_AND_REVISION_IDENT_OFS   = 8'h08;
  localparam logic [7:0] LATENCY_AND_LINE_SIZE_OFS      = 8'h0C;
  localparam logic [7:0] HEADER_LAYOUT_AND_SELFTEST_OFS = 8'h0E;
  localparam logic [7:0] DWORD_ALIGN_MASK               = 8'hFC;

  // ----------------------------------------------------------------
  // Fixed identification fields
  // ----------------------------------------------------------------
  localparam logic [7:0] BROAD_FUNCTION_CATEGORY  = 8'h0C;
  localparam logic [7:0] NARROW_FUNCTION_CATEGORY = 8'h00;
  localparam logic [7:0] PROGRAMMING_MODEL_CODE   = 8'h10;
  localparam logic [7:0] SELF_CHECK_FIELD         = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT_FIELD      = 8'h00;

  // ----------------------------------------------------------------
  // Byte lanes inside a configuration dword
  // ----------------------------------------------------------------
  localparam int LINE_SIZE_LANE    = 0;
  localparam int LATENCY_LANE      = 1;
  localparam int HEADER_LAYOUT_LANE = 2;
  localparam int SELF_CHECK_LANE   = 3;
  localparam int BROAD_CATEGORY_LANE    = 3;
  localparam int NARROW_CATEGORY_LANE   = 2;
  localparam int PROGRAMMING_MODEL_LANE = 1;
  localparam int SILICON_REVISION_LANE  = 0;
  localparam int LANE_W                 = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  LINE_SIZE_RESET     = 8'h00;
  localparam logic [7:0]  LATENCY_RESET       = 8'h00;
  localparam logic [31:0] RDATA_RESET         = 32'h0000_0000;
  localparam logic [31:0] EMPTY_WORD          = 32'h0000_0000;
  localparam logic [7:0]  LATENCY_COUNT_START = 8'h00;
  localparam logic [7:0]  LATENCY_COUNT_STEP  = 8'h01;
  localparam logic [7:0]  LATENCY_COUNT_MAX   = 8'hFF;

  // Latency counter states.
  typedef enum logic [0:0] {
    PCH_LAT_IDLE,
    PCH_LAT_RUN
  } pch_lat_state_t;

endpackage

// ===== hdl/pch_config_header.sv
// Configuration header slice: class and revision, latency timer, header layout.
`timescale 1ns/1ps

// Contract
// (RULE_01) Bits 31:24 of identification read 0Ch.
// (RULE_02) Bits 23:16 of identification read 00h.
// (RULE_03) Bits 15:8 of identification read 10h.
// (RULE_04) Low identification byte is fixed silicon revision.
// (RULE_05) Class and revision register is read-only.
// (RULE_06) Writable latency value at 0Ch bits 15:8.
// (RULE_07) Counter starts at zero on FRAME, counts clocks.
// (RULE_08) Expired and grant removed ends the transaction.
// (RULE_09) Writable line size in bits 7:0, used.
// (RULE_10) Self-check field at 0Eh reads 00h; the code places it in lane 3 (byte 0Fh) and reads 00h there.
// (RULE_11) Header layout field reads 00h.
// (RULE_12) Read-only writes ignored; only addressed bytes update.
module pch_config_header #(
  // Arbitrary value; the real code is fixed by the silicon.
  parameter logic [7:0] SILICON_REVISION = 8'h5A,
  parameter int         LAT_W            = 8
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Configuration access port
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata_ff,
  output logic             cfg_rvalid_ff,
  // Bus master transaction logic
  input  wire logic        frame_start,
  input  wire logic        master_active,
  input  wire logic        gnt_n,
  output logic             lat_expired_ff,
  output logic             master_stop_ff,
  // Settings used by the bus master
  output logic      [7:0]  line_size_setting_ff,
  output logic      [7:0]  latency_value_ff
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (LAT_W != 8)
  begin : g_bad_width
    $error("pch_config_header: LAT_W must be 8");
  end

  // Both settings bytes need lanes of their own or one write would land twice.
  if (pch_pkg::LINE_SIZE_LANE == pch_pkg::LATENCY_LANE)
  begin : g_bad_lanes
    $error("pch_config_header: settings lanes overlap");
  end

  // Offsets must be dword aligned because the decode drops the low address bits.
  if ((pch_pkg::LATENCY_AND_LINE_SIZE_OFS & pch_pkg::DWORD_ALIGN_MASK)
      != pch_pkg::LATENCY_AND_LINE_SIZE_OFS)
  begin : g_bad_offset
    $error("pch_config_header: settings offset not dword aligned");
  end

  if ((pch_pkg::CLASS_AND_REVISION_IDENT_OFS & pch_pkg::DWORD_ALIGN_MASK)
      != pch_pkg::CLASS_AND_REVISION_IDENT_OFS)
  begin : g_bad_ident_offset
    $error("pch_config_header: identification offset not dword aligned");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_lane(input logic [31:0] word, input int lane);
    pick_lane = word[lane*pch_pkg::LANE_W +: pch_pkg::LANE_W];
  endfunction

  // Places one byte into its lane of an otherwise empty dword.
  function automatic logic [31:0] place_lane(input logic [7:0] value, input int lane);
    place_lane = pch_pkg::EMPTY_WORD;
    place_lane[lane*pch_pkg::LANE_W +: pch_pkg::LANE_W] = value;
  endfunction

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
    hits = ((addr & pch_pkg::DWORD_ALIGN_MASK) == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Grant synchroniser
  // ----------------------------------------------------------------
  logic gnt_meta_ff;
  logic gnt_sync_ff;
  logic nxt_gnt_meta;
  logic nxt_gnt_sync;

  always_comb
  begin
    nxt_gnt_meta = gnt_n;
    nxt_gnt_sync = gnt_meta_ff;
  end

  // Grant is released high so reset holds it as deasserted.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      gnt_meta_ff <= 1'b1;
      gnt_sync_ff <= 1'b1;
    end
    else
    begin
      gnt_meta_ff <= nxt_gnt_meta;
      gnt_sync_ff <= nxt_gnt_sync;
    end
  end

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [7:0]  nxt_line_size;
  logic [7:0]  nxt_latency;
  logic [31:0] nxt_rdata;
  logic        nxt_rvalid;
  logic [31:0] ident_word;
  logic [31:0] lat_word;

  always_comb
  begin
    nxt_line_size = line_size_setting_ff;
    nxt_latency   = latency_value_ff;
    // (RULE_05) Identification ignores writes.
    // (RULE_12) Per-lane write enables.
    if (cfg_wr && hits(cfg_addr, pch_pkg::LATENCY_AND_LINE_SIZE_OFS))
    begin
      // (RULE_09) Line size write.
      if (cfg_be[pch_pkg::LINE_SIZE_LANE])
      begin
        nxt_line_size = pick_lane(cfg_wdata, pch_pkg::LINE_SIZE_LANE);
      end
      // (RULE_06) Latency value write.
      if (cfg_be[pch_pkg::LATENCY_LANE])
      begin
        nxt_latency = pick_lane(cfg_wdata, pch_pkg::LATENCY_LANE);
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      line_size_setting_ff <= pch_pkg::LINE_SIZE_RESET;
      latency_value_ff     <= pch_pkg::LATENCY_RESET;
    end
    else
    begin
      line_size_setting_ff <= nxt_line_size;
      latency_value_ff     <= nxt_latency;
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // The answer is built from the registered settings, so a read that meets a
  // write in the same cycle returns the old value.
  always_comb
  begin
    ident_word = pch_pkg::EMPTY_WORD;
    // (RULE_01) Base category byte.
    ident_word = ident_word
                 | place_lane(pch_pkg::BROAD_FUNCTION_CATEGORY, pch_pkg::BROAD_CATEGORY_LANE);
    // (RULE_02) Sub category byte.
    ident_word = ident_word
                 | place_lane(pch_pkg::NARROW_FUNCTION_CATEGORY, pch_pkg::NARROW_CATEGORY_LANE);
    // (RULE_03) Programming model byte.
    ident_word = ident_word
                 | place_lane(pch_pkg::PROGRAMMING_MODEL_CODE, pch_pkg::PROGRAMMING_MODEL_LANE);
    // (RULE_04) Fixed revision byte.
    ident_word = ident_word | place_lane(SILICON_REVISION, pch_pkg::SILICON_REVISION_LANE);

    lat_word = pch_pkg::EMPTY_WORD;
    // (RULE_10) Self-check reads zero.
    lat_word = lat_word | place_lane(pch_pkg::SELF_CHECK_FIELD, pch_pkg::SELF_CHECK_LANE);
    // (RULE_11) Header layout reads zero.
    lat_word = lat_word | place_lane(pch_pkg::HEADER_LAYOUT_FIELD, pch_pkg::HEADER_LAYOUT_LANE);
    lat_word = lat_word | place_lane(latency_value_ff, pch_pkg::LATENCY_LANE);
    lat_word = lat_word | place_lane(line_size_setting_ff, pch_pkg::LINE_SIZE_LANE);

    // Unmapped dwords read as zero so probing software sees an empty slot.
    nxt_rvalid = cfg_rd;
    nxt_rdata  = pch_pkg::RDATA_RESET;
    if (cfg_rd)
    begin
      if (hits(cfg_addr, pch_pkg::CLASS_AND_REVISION_IDENT_OFS))
      begin
        nxt_rdata = ident_word;
      end
      else if (hits(cfg_addr, pch_pkg::LATENCY_AND_LINE_SIZE_OFS))
      begin
        nxt_rdata = lat_word;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cfg_rdata_ff  <= pch_pkg::RDATA_RESET;
      cfg_rvalid_ff <= 1'b0;
    end
    else
    begin
      cfg_rdata_ff  <= nxt_rdata;
      cfg_rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Latency counter
  // ----------------------------------------------------------------
  pch_pkg::pch_lat_state_t lat_state_ff;
  pch_pkg::pch_lat_state_t nxt_lat_state;
  logic [7:0] lat_count_ff;
  logic [7:0] nxt_lat_count;
  logic       nxt_expired;
  logic       nxt_stop;

  always_comb
  begin
    nxt_lat_state = lat_state_ff;
    nxt_lat_count = lat_count_ff;
    case (lat_state_ff)
      pch_pkg::PCH_LAT_IDLE:
      begin
        // (RULE_07) Start from zero.
        if (frame_start)
        begin
          nxt_lat_state = pch_pkg::PCH_LAT_RUN;
          nxt_lat_count = pch_pkg::LATENCY_COUNT_START;
        end
      end
      pch_pkg::PCH_LAT_RUN:
      begin
        // (RULE_07) Restart or advance.
        if (frame_start)
        begin
          nxt_lat_count = pch_pkg::LATENCY_COUNT_START;
        end
        else if (!master_active)
        begin
          nxt_lat_state = pch_pkg::PCH_LAT_IDLE;
        end
        else if (lat_count_ff != pch_pkg::LATENCY_COUNT_MAX)
        begin
          // Saturating keeps a long burst from wrapping back under the limit.
          nxt_lat_count = 8'(lat_count_ff + pch_pkg::LATENCY_COUNT_STEP);
        end
      end
      default:
      begin
        nxt_lat_state = pch_pkg::PCH_LAT_IDLE;
        nxt_lat_count = pch_pkg::LATENCY_COUNT_START;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lat_state_ff <= pch_pkg::PCH_LAT_IDLE;
      lat_count_ff <= pch_pkg::LATENCY_COUNT_START;
    end
    else
    begin
      lat_state_ff <= nxt_lat_state;
      lat_count_ff <= nxt_lat_count;
    end
  end

  // ----------------------------------------------------------------
  // Expiry and termination flags
  // ----------------------------------------------------------------
  // The flags look at the count being registered, so expiry shows on the same
  // edge as the count that reaches the limit rather than one clock late.
  always_comb
  begin
    // (RULE_08) Expiry and grant removal.
    nxt_expired = (nxt_lat_state == pch_pkg::PCH_LAT_RUN) && master_active
                  && (nxt_lat_count >= latency_value_ff);
    // A high synchronised grant means the arbiter has taken the bus away.
    nxt_stop    = nxt_expired && gnt_sync_ff;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lat_expired_ff <= 1'b0;
      master_stop_ff <= 1'b0;
    end
    else
    begin
      lat_expired_ff <= nxt_expired;
      master_stop_ff <= nxt_stop;
    end
  end

endmodule

// ===== tb/pch_host_model.sv
// Host bridge arbiter model driving the grant pin.
`timescale 1ns/1ps
module pch_host_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Grant control and pin
  input  wire logic grant_on,
  output logic      gnt_n
);
  logic gnt_n_ff;
  logic nxt_gnt_n;
  // The grant moves only on an edge, as a real arbiter's output would.
  always_comb nxt_gnt_n = reset ? 1'b1 : !grant_on;
  always_ff @(posedge ref_clk) gnt_n_ff <= nxt_gnt_n;
  assign gnt_n = gnt_n_ff;
endmodule

// ===== tb/pch_config_header_props.sv
// Checker for the configuration header slice.
`timescale 1ns/1ps
module pch_config_header_props (
  // Watched ports
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata_ff,
  input wire logic        cfg_rvalid_ff,
  input wire logic        frame_start,
  input wire logic        master_active,
  input wire logic        gnt_n,
  input wire logic        lat_expired_ff,
  input wire logic        master_stop_ff,
  input wire logic [7:0]  line_size_setting_ff,
  input wire logic [7:0]  latency_value_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire hit = cfg_addr[7:2] == 6'h03;
  a_id_value: assert property (cfg_rd && cfg_addr[7:2] == 6'h02
    |=> cfg_rdata_ff[31:8] == 24'h0C0010) else $error("bad id");
  a_hdr_zero: assert property (cfg_rd && hit
    |=> cfg_rdata_ff[31:16] == 16'h0000) else $error("bad header");
  a_lat_write: assert property (cfg_wr && hit && cfg_be[1]
    |=> latency_value_ff == $past(cfg_wdata[15:8])) else $error("bad latency");
  a_line_write: assert property (cfg_wr && hit && cfg_be[0]
    |=> line_size_setting_ff == $past(cfg_wdata[7:0])) else $error("bad line");
  a_lat_hold: assert property (!(cfg_wr && hit && cfg_be[1])
    |=> $stable(latency_value_ff)) else $error("latency moved");
  a_expire_time: assert property (frame_start && master_active && !cfg_wr
    && latency_value_ff == 8'h02 ##1 (master_active && !frame_start && !cfg_wr) [*2]
    |=> lat_expired_ff) else $error("late expiry");
  a_stop_cause: assert property (master_stop_ff |-> lat_expired_ff)
    else $error("stop early");
  a_stop_grant: assert property (gnt_n [*4] ##1 lat_expired_ff
    |-> master_stop_ff) else $error("no stop");
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid_ff)
    else $error("no read answer");
  a_read_quiet: assert property (!cfg_rd |=> !cfg_rvalid_ff && cfg_rdata_ff == 32'h0)
    else $error("stray read answer");
  cover property (cfg_wr && hit);
  cover property (lat_expired_ff && !master_stop_ff);
  cover property (master_stop_ff);
  cover property (cfg_rd && hit);
endmodule

bind pch_config_header pch_config_header_props i_props (.ref_clk(ref_clk), .reset(reset),
  .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
  .cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff), .cfg_rvalid_ff(cfg_rvalid_ff),
  .frame_start(frame_start),
  .master_active(master_active), .gnt_n(gnt_n), .lat_expired_ff(lat_expired_ff),
  .master_stop_ff(master_stop_ff), .line_size_setting_ff(line_size_setting_ff),
  .latency_value_ff(latency_value_ff));

// ===== tb/test_pch_config_header.sv
// Self-checking bench for the configuration header slice.
`timescale 1ns/1ps
module test_pch_config_header;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value.
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cfg_rd = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic        frame_start = 1'b0;
  logic        master_active = 1'b0;
  logic        grant_on = 1'b1;
  logic        gnt_n, rvalid, expired, stop;
  logic [31:0] rdata;
  logic [7:0]  line, lat;
  int          err_count = 0;
  int          cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  pch_host_model i_host (.ref_clk(ref_clk), .reset(reset), .grant_on(grant_on), .gnt_n(gnt_n));
  pch_config_header #(.SILICON_REVISION(REV)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata_ff(rdata), .cfg_rvalid_ff(rvalid),
    .frame_start(frame_start), .master_active(master_active), .gnt_n(gnt_n),
    .lat_expired_ff(expired), .master_stop_ff(stop), .line_size_setting_ff(line),
    .latency_value_ff(lat));
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    // A lost answer must not hang the run.
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 4)
    begin
      err_count++;
      summarize();
    end
    else
      chk("read data", e, rdata);
  endtask
  task lat_run(input logic g, input logic s);
    @(posedge ref_clk);
    grant_on <= g;
    repeat (5) @(posedge ref_clk);
    frame_start <= 1'b1;
    master_active <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      frame_start <= 1'b0;
      // The transaction ends right after the edge on which the limit is reached.
      if (i == 2)
        master_active <= 1'b0;
      #1;
      chk("expired", {31'h0, i == 2}, {31'h0, expired});
    end
    chk("stop", {31'h0, s}, {31'h0, stop});
    repeat (2) @(posedge ref_clk);
    #1;
    chk("stop cleared", 32'h0, {31'h0, stop});
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h0C, 32'h0000_0000);
    wr(8'h08, 4'hF, 32'hFFFF_FFFF);
    rd(8'h08, {8'h0C, 8'h00, 8'h10, REV});
    $display("test identification done");
    wr(8'h0C, 4'hF, 32'hFFFF_2010);
    rd(8'h0E, 32'h0000_2010);
    wr(8'h0C, 4'h2, 32'h1122_0244);
    rd(8'h0C, 32'h0000_0210);
    chk("line size", 32'h10, {24'h0, line});
    chk("latency", 32'h02, {24'h0, lat});
    rd(8'h10, 32'h0000_0000);
    $display("test registers done");
    lat_run(1'b1, 1'b0);
    lat_run(1'b0, 1'b1);
    $display("test latency done");
    summarize();
  end
endmodule
